// [rtl/tsc_pkg.sv]
// Shared constants and types for the trace sequencer capture block
package tsc_pkg;
	localparam int DATA_W = 48;
	localparam int LVL_W = 4;
	localparam int WORD_W = 52;
	localparam int MEM_DEPTH = 515;
	localparam int MEM_PIPE = 3;
	localparam int ADDR_W = 10;
	localparam int PASS_W = 14;
	localparam int NLVL = 16;
	localparam logic [PASS_W-1:0] PASS_LIM_RST = 14'h0001;
	localparam logic [15:0] DLY_RST = 16'h0001;
	localparam logic [15:0] COND_RST = 16'h2222;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_PASS = 8'h0C;
	localparam logic [7:0] OFS_LSEL = 8'h10;
	localparam logic [7:0] OFS_LCFG = 8'h14;
	localparam logic [7:0] OFS_LCOND = 8'h18;
	localparam logic [7:0] OFS_VAL_LO = 8'h1C;
	localparam logic [7:0] OFS_VAL_HI = 8'h20;
	localparam logic [7:0] OFS_MSK_LO = 8'h24;
	localparam logic [7:0] OFS_MSK_HI = 8'h28;
	localparam logic [7:0] OFS_SVAL_LO = 8'h2C;
	localparam logic [7:0] OFS_SVAL_HI = 8'h30;
	localparam logic [7:0] OFS_SMSK_LO = 8'h34;
	localparam logic [7:0] OFS_SMSK_HI = 8'h38;
	localparam logic [7:0] OFS_CHN_LO = 8'h3C;
	localparam logic [7:0] OFS_CHN_HI = 8'h40;
	localparam logic [7:0] OFS_CURS = 8'h44;
	localparam logic [7:0] OFS_SRES = 8'h48;
	localparam logic [7:0] OFS_SCNT = 8'h4C;
	localparam logic [7:0] OFS_MADDR = 8'h50;
	localparam logic [7:0] OFS_MDAT_LO = 8'h54;
	localparam logic [7:0] OFS_MDAT_HI = 8'h58;
	localparam int CMD_ARM = 0;
	localparam int CMD_ADV = 1;
	localparam int CMD_XFER = 2;
	localparam int CMD_STOP = 3;
	localparam int CMD_SRCH = 4;
	localparam int CMD_CMP = 5;
	localparam int CTRL_ASC_LSB = 2;
	localparam int CTRL_SRC_BIT = 4;
	localparam int LCFG_JMP_LSB = 16;
	localparam int LCFG_CMODE_BIT = 20;
	localparam int HI_LSB = 16;
	localparam int ACT_STOP = 0;
	localparam int ACT_JMP = 1;
	localparam int ACT_ADV = 2;
	localparam int ACT_TRC = 3;
	localparam logic [1:0] MSEL_M = 2'h0;
	localparam logic [1:0] MSEL_A = 2'h1;
	localparam logic [1:0] MSEL_B = 2'h2;
	typedef enum logic [3:0] {COND_MATCH = 4'b0000, COND_ALWAYS = 4'b0001, COND_NEVER = 4'b0010,
		COND_GT = 4'b0011, COND_LT = 4'b0100, COND_EQ = 4'b0101, COND_GE = 4'b0110,
		COND_LE = 4'b0111, COND_NE = 4'b1000} tsc_cond_e;
	typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_CLEAR = 3'b001, ST_RUN = 3'b010,
		ST_XFER = 3'b011, ST_CMP = 3'b100, ST_SRCH = 3'b101} tsc_state_e;
	typedef enum logic [1:0] {MODE_MANUAL = 2'b00, MODE_AUTO = 2'b01, MODE_ASTOP = 2'b10,
		MODE_AWIN = 2'b11} tsc_mode_e;
	typedef enum logic [1:0] {ASC_EQ = 2'b00, ASC_NE = 2'b01, ASC_LIM = 2'b10} tsc_asc_e;
endpackage

// [rtl/tsc_mem.sv]
// Simple dual-port word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tsc_mem
	import tsc_pkg::*;
#(
	parameter int W = WORD_W,
	parameter int DEPTH = MEM_DEPTH,
	parameter int AW = ADDR_W
)(
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	if (DEPTH > 2**AW || DEPTH < 2)
	begin : g_chk
		$error("tsc_mem: DEPTH does not fit AW");
	end
	logic [W-1:0] mem_q [DEPTH];
	// No reset on the array; contents are flushed by the core when needed
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem_q[i_waddr] <= i_wdata;
		o_rdata <= mem_q[i_raddr];
	end
endmodule
`default_nettype wire

// [rtl/tsc_cond.sv]
// One level action condition: masked pattern plus count versus delay
`timescale 1ns/1ps
`default_nettype none
module tsc_cond
	import tsc_pkg::*;
#(
	parameter int W = DATA_W
)(
	input wire logic [3:0] i_cond,
	input wire logic [W-1:0] i_data,
	input wire logic [W-1:0] i_val,
	input wire logic [W-1:0] i_msk,
	input wire logic [15:0] i_cnt,
	input wire logic [15:0] i_dly,
	output logic o_pm,
	output logic o_hit
);
	if (W < 1)
	begin : g_chk
		$error("tsc_cond: W must be positive");
	end
	// Mask bit low means don't care
	assign o_pm = ((i_data ^ i_val) & i_msk) == '0;
	// Undefined codes behave as never
	always_comb
	begin
		case (tsc_cond_e'(i_cond))
			COND_MATCH: o_hit = o_pm;
			COND_ALWAYS: o_hit = 1'b1;
			COND_GT: o_hit = o_pm && i_cnt > i_dly;
			COND_LT: o_hit = o_pm && i_cnt < i_dly;
			COND_EQ: o_hit = o_pm && i_cnt == i_dly;
			COND_GE: o_hit = o_pm && i_cnt >= i_dly;
			COND_LE: o_hit = o_pm && i_cnt <= i_dly;
			COND_NE: o_hit = o_pm && i_cnt != i_dly;
			default: o_hit = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// [rtl/tsc_core.sv]
// Trace sequencer, capture memories, search, compare and arm control
`timescale 1ns/1ps
`default_nettype none
module tsc_core
	import tsc_pkg::*;
#(
	parameter int DEPTH = MEM_DEPTH,
	parameter int PIPE = MEM_PIPE
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_smp_valid,
	input wire logic [DATA_W-1:0] i_smp_data,
	output logic [LVL_W-1:0] o_level,
	output logic o_armed
);
	if (DEPTH > 2**ADDR_W - 1 || PIPE >= DEPTH || PIPE < 0)
	begin : g_chk
		$error("tsc_core: unsupported DEPTH or PIPE");
	end
	localparam logic [ADDR_W-1:0] LAST = ADDR_W'(DEPTH - 1);
	localparam logic [ADDR_W-1:0] FIRST = ADDR_W'(PIPE);
	localparam logic [LVL_W-1:0] TOP = 4'hF;

	logic [1:0] mode_q;
	logic [1:0] asc_q;
	logic src_q;
	logic [PASS_W-1:0] lim_q;
	logic [PASS_W-1:0] pass_q;
	logic [3:0] lsel_q;
	logic [1:0] asel_q;
	logic [15:0] dly_q [NLVL];
	logic [3:0] jmp_q [NLVL];
	logic cmode_q [NLVL];
	logic [15:0] cnd_q [NLVL];
	logic [DATA_W-1:0] val_q [NLVL][4];
	logic [DATA_W-1:0] msk_q [NLVL][4];
	logic [DATA_W-1:0] sval_q;
	logic [DATA_W-1:0] smsk_q;
	logic [DATA_W-1:0] chn_q;
	logic [ADDR_W-1:0] clo_q;
	logic [ADDR_W-1:0] chi_q;
	logic [ADDR_W-1:0] maddr_q;
	logic [1:0] msel_q;
	logic [31:0] wlo_q;
	logic [31:0] rd_mux;
	logic rd_ph_q;
	tsc_state_e st_q;
	tsc_state_e st_d;
	logic [3:0] lvl_q;
	logic [15:0] cnt_q;
	logic [ADDR_W-1:0] wptr_q;
	logic [ADDR_W-1:0] walk_q;
	logic [ADDR_W-1:0] wd1_q;
	logic wv_q;
	logic halt_q;
	logic autoc_q;
	logic [ADDR_W-1:0] sfirst_q;
	logic [ADDR_W-1:0] slast_q;
	logic [ADDR_W-1:0] scnt_q;
	logic [ADDR_W-1:0] dcnt_q;
	logic [DEPTH-1:0] mark_q;
	logic [DEPTH-1:0] diff_q;
	logic [WORD_W-1:0] m_q;
	logic [WORD_W-1:0] a_q;
	logic [WORD_W-1:0] b_q;
	logic [3:0] hit;
	logic [3:0] pm;

	// Bus decode; commands are one-cycle write pulses
	wire wr = i_avs_write;
	wire [7:0] ofs = i_avs_address;
	wire [31:0] wd = i_avs_writedata;
	wire wcmd = wr && ofs == OFS_CMD;
	wire cmd_arm = wcmd && wd[CMD_ARM];
	wire cmd_adv = wcmd && wd[CMD_ADV];
	wire cmd_xfer = wcmd && wd[CMD_XFER];
	wire cmd_stop = wcmd && wd[CMD_STOP];
	wire cmd_srch = wcmd && wd[CMD_SRCH];
	wire cmd_cmp = wcmd && wd[CMD_CMP];
	wire idle = st_q == ST_IDLE;

	// Sequencer evaluation of the current level
	wire sample = st_q == ST_RUN && i_smp_valid;
	wire inc = cmode_q[lvl_q] ? pm[ACT_ADV] : 1'b1;
	wire [15:0] cnt_n = (inc && cnt_q != 16'hFFFF) ? cnt_q + 16'h0001 : cnt_q;
	wire stop_h = hit[ACT_STOP];
	wire jmp_h = hit[ACT_JMP];
	wire adv_h = hit[ACT_ADV];
	wire store = sample && hit[ACT_TRC] && wptr_q <= LAST;
	wire fadv = cmd_adv && st_q == ST_RUN;
	wire [3:0] jtgt = jmp_q[lvl_q];
	wire up = lvl_q != TOP;
	for (genvar g = 0; g < 4; g++)
	begin : g_act
		tsc_cond #(.W(DATA_W)) u_cond (
			.i_cond(cnd_q[lvl_q][4*g +: 4]),
			.i_data(i_smp_data),
			.i_val(val_q[lvl_q][g]),
			.i_msk(msk_q[lvl_q][g]),
			.i_cnt(cnt_n),
			.i_dly(dly_q[lvl_q]),
			.o_pm(pm[g]),
			.o_hit(hit[g])
		);
	end

	// Memory walk shared by flush, transfer, compare and search
	wire rd_walk = st_q == ST_XFER || st_q == ST_CMP || st_q == ST_SRCH;
	wire done = wv_q && wd1_q == LAST;
	wire restart = cmd_arm || st_d != st_q;
	wire rearm = st_d == ST_CLEAR && (cmd_arm || st_q != ST_CLEAR);
	wire lim_x = pass_q + 14'h0001 >= lim_q;
	wire lim_c = pass_q >= lim_q;
	wire inwin = mode_q != MODE_AWIN || (wd1_q >= clo_q && wd1_q <= chi_q);
	wire [DATA_W-1:0] cmask = mode_q == MODE_AWIN ? chn_q : '1;
	wire cur_diff = inwin && ((a_q[DATA_W-1:0] ^ b_q[DATA_W-1:0]) & cmask) != '0;
	wire unequal = dcnt_q != '0 || cur_diff;
	wire [WORD_W-1:0] s_q = src_q ? b_q : a_q;
	wire cur_hit = ((s_q[DATA_W-1:0] ^ sval_q) & smsk_q) == '0;
	wire stop_c = asc_q == ASC_EQ ? !unequal : asc_q == ASC_NE ? unequal : 1'b0;

	// Memory port selection; bus reads see memories only while idle
	wire m_we = st_q == ST_CLEAR || store;
	wire [ADDR_W-1:0] m_wa = st_q == ST_CLEAR ? walk_q : wptr_q;
	wire [WORD_W-1:0] m_wd = st_q == ST_CLEAR ? '0 : {lvl_q, i_smp_data};
	wire [ADDR_W-1:0] raddr = idle ? maddr_q : walk_q;
	wire a_we = st_q == ST_XFER && wv_q;
	wire b_we = wr && ofs == OFS_MDAT_HI && idle && msel_q == MSEL_B;
	wire [WORD_W-1:0] b_wd = {wd[WORD_W-33:0], wlo_q};
	wire [WORD_W-1:0] mq = msel_q == MSEL_M ? m_q : msel_q == MSEL_A ? a_q : b_q;
	wire aok = maddr_q <= LAST;
	wire mk = aok && mark_q[maddr_q];
	wire df = aok && diff_q[maddr_q];

	tsc_mem #(.W(WORD_W), .DEPTH(DEPTH), .AW(ADDR_W)) u_mem_m (.i_clk(i_clk), .i_we(m_we),
		.i_waddr(m_wa), .i_wdata(m_wd), .i_raddr(raddr), .o_rdata(m_q));
	tsc_mem #(.W(WORD_W), .DEPTH(DEPTH), .AW(ADDR_W)) u_mem_a (.i_clk(i_clk), .i_we(a_we),
		.i_waddr(wd1_q), .i_wdata(m_q), .i_raddr(raddr), .o_rdata(a_q));
	tsc_mem #(.W(WORD_W), .DEPTH(DEPTH), .AW(ADDR_W)) u_mem_b (.i_clk(i_clk), .i_we(b_we),
		.i_waddr(maddr_q), .i_wdata(b_wd), .i_raddr(raddr), .o_rdata(b_q));

	// Arm mode controller; arm overrides every state
	always_comb
	begin
		st_d = st_q;
		if (cmd_arm)
			st_d = ST_CLEAR;
		else
		begin
			case (st_q)
				ST_IDLE:
					if (cmd_srch)
						st_d = ST_SRCH;
					else if (cmd_cmp)
						st_d = ST_CMP;
					else if (cmd_xfer)
						st_d = ST_XFER;
				ST_CLEAR:
					if (cmd_stop)
						st_d = ST_IDLE;
					else if (walk_q == LAST)
						st_d = ST_RUN;
				ST_RUN:
					if (cmd_stop)
						st_d = ST_IDLE;
					else if (cmd_xfer || (sample && stop_h))
						st_d = ST_XFER;
				ST_XFER:
					if (done)
					begin
						if (halt_q || mode_q == MODE_MANUAL)
							st_d = ST_IDLE;
						else if (mode_q == MODE_AUTO)
							st_d = lim_x ? ST_IDLE : ST_CLEAR;
						else
							st_d = ST_CMP;
					end
				ST_CMP:
					if (cmd_stop)
						st_d = ST_IDLE;
					else if (done)
						st_d = (!autoc_q || stop_c || lim_c) ? ST_IDLE : ST_CLEAR;
				ST_SRCH:
					if (done || cmd_stop)
						st_d = ST_IDLE;
				default: st_d = ST_IDLE;
			endcase
		end
	end

	// Per-level programming through the level and action selectors
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			for (int i = 0; i < NLVL; i++)
			begin
				dly_q[i] <= DLY_RST;
				jmp_q[i] <= 4'h0;
				cmode_q[i] <= 1'b0;
				cnd_q[i] <= COND_RST;
				for (int j = 0; j < 4; j++)
				begin
					val_q[i][j] <= '0;
					msk_q[i][j] <= '0;
				end
			end
		end
		else if (wr)
		begin
			case (ofs)
				OFS_LCFG:
				begin
					dly_q[lsel_q] <= wd[15:0] == 16'h0000 ? DLY_RST : wd[15:0];
					jmp_q[lsel_q] <= wd[LCFG_JMP_LSB +: 4];
					cmode_q[lsel_q] <= wd[LCFG_CMODE_BIT];
				end
				OFS_LCOND: cnd_q[lsel_q] <= wd[15:0];
				OFS_VAL_LO: val_q[lsel_q][asel_q][31:0] <= wd;
				OFS_VAL_HI: val_q[lsel_q][asel_q][DATA_W-1:32] <= wd[DATA_W-33:0];
				OFS_MSK_LO: msk_q[lsel_q][asel_q][31:0] <= wd;
				OFS_MSK_HI: msk_q[lsel_q][asel_q][DATA_W-1:32] <= wd[DATA_W-33:0];
				default: ;
			endcase
		end
	end

	// Global control registers
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			mode_q <= MODE_MANUAL;
			asc_q <= ASC_EQ;
			src_q <= 1'b0;
			lim_q <= PASS_LIM_RST;
			lsel_q <= 4'h0;
			asel_q <= 2'h0;
			sval_q <= '0;
			smsk_q <= '0;
			chn_q <= '1;
			clo_q <= '0;
			chi_q <= LAST;
			maddr_q <= '0;
			msel_q <= MSEL_M;
			wlo_q <= 32'h0;
		end
		else if (wr)
		begin
			case (ofs)
				OFS_CTRL:
				begin
					mode_q <= wd[1:0];
					asc_q <= wd[CTRL_ASC_LSB +: 2];
					src_q <= wd[CTRL_SRC_BIT];
				end
				OFS_PASS: lim_q <= wd[PASS_W-1:0] == '0 ? PASS_LIM_RST : wd[PASS_W-1:0];
				OFS_LSEL:
				begin
					lsel_q <= wd[3:0];
					asel_q <= wd[5:4];
				end
				OFS_SVAL_LO: sval_q[31:0] <= wd;
				OFS_SVAL_HI: sval_q[DATA_W-1:32] <= wd[DATA_W-33:0];
				OFS_SMSK_LO: smsk_q[31:0] <= wd;
				OFS_SMSK_HI: smsk_q[DATA_W-1:32] <= wd[DATA_W-33:0];
				OFS_CHN_LO: chn_q[31:0] <= wd;
				OFS_CHN_HI: chn_q[DATA_W-1:32] <= wd[DATA_W-33:0];
				OFS_CURS:
				begin
					clo_q <= wd[ADDR_W-1:0];
					chi_q <= wd[HI_LSB +: ADDR_W];
				end
				OFS_MADDR:
				begin
					maddr_q <= wd[ADDR_W-1:0];
					msel_q <= wd[HI_LSB +: 2];
				end
				OFS_MDAT_LO: wlo_q <= wd;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		case (ofs)
			OFS_CTRL: rd_mux = {27'h0, src_q, asc_q, mode_q};
			OFS_STAT: rd_mux = {2'h0, pass_q, 8'h0, lvl_q, 1'b0, st_q};
			OFS_PASS: rd_mux = {18'h0, lim_q};
			OFS_LSEL: rd_mux = {26'h0, asel_q, lsel_q};
			OFS_LCFG: rd_mux = {11'h0, cmode_q[lsel_q], jmp_q[lsel_q], dly_q[lsel_q]};
			OFS_LCOND: rd_mux = {16'h0, cnd_q[lsel_q]};
			OFS_CURS: rd_mux = {6'h0, chi_q, 6'h0, clo_q};
			OFS_SRES: rd_mux = {6'h0, slast_q, 6'h0, sfirst_q};
			OFS_SCNT: rd_mux = {6'h0, dcnt_q, 6'h0, scnt_q};
			OFS_MADDR: rd_mux = {14'h0, msel_q, 6'h0, maddr_q};
			OFS_MDAT_LO: rd_mux = mq[31:0];
			OFS_MDAT_HI: rd_mux = {10'h0, df, mk, mq[WORD_W-1:32]};
			default: rd_mux = 32'h0;
		endcase
	end

	// Reads wait one cycle so that read data come from a register
	assign o_avs_waitrequest = i_avs_read && !rd_ph_q;
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			rd_ph_q <= 1'b0;
			o_avs_readdata <= 32'h0;
		end
		else
		begin
			rd_ph_q <= i_avs_read && !rd_ph_q;
			if (i_avs_read && !rd_ph_q)
				o_avs_readdata <= rd_mux;
		end
	end

	// State, walk pointer and pass bookkeeping
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			st_q <= ST_IDLE;
			walk_q <= '0;
			wd1_q <= '0;
			wv_q <= 1'b0;
			halt_q <= 1'b0;
			autoc_q <= 1'b0;
			pass_q <= '0;
			wptr_q <= FIRST;
		end
		else
		begin
			st_q <= st_d;
			walk_q <= restart ? '0 : (walk_q == LAST ? walk_q : walk_q + ADDR_W'(1));
			wd1_q <= walk_q;
			wv_q <= rd_walk && !restart;
			halt_q <= cmd_arm ? 1'b0 : (cmd_stop || cmd_xfer) ? 1'b1 : halt_q;
			autoc_q <= st_q == ST_XFER ? 1'b1 : (idle ? 1'b0 : autoc_q);
			if (cmd_arm)
				pass_q <= '0;
			else if (st_q == ST_XFER && done)
				pass_q <= pass_q + PASS_W'(1);
			if (rearm)
				wptr_q <= FIRST;
			else if (store)
				wptr_q <= wptr_q + ADDR_W'(1);
		end
	end

	// Level sequencing: forced advance, then stop, jump, advance
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn || rearm)
		begin
			lvl_q <= 4'h0;
			cnt_q <= 16'h0;
		end
		else if (fadv)
		begin
			lvl_q <= up ? lvl_q + 4'h1 : lvl_q;
			cnt_q <= 16'h0;
		end
		else if (sample && !stop_h)
		begin
			if (jmp_h)
			begin
				lvl_q <= jtgt;
				cnt_q <= 16'h0;
			end
			else if (adv_h && up)
			begin
				lvl_q <= lvl_q + 4'h1;
				cnt_q <= 16'h0;
			end
			else
				cnt_q <= cnt_n;
		end
	end

	// Search and compare marks; set only while walking
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn || (restart && st_d == ST_SRCH))
		begin
			mark_q <= '0;
			scnt_q <= '0;
			sfirst_q <= '0;
			slast_q <= '0;
		end
		else if (st_q == ST_SRCH && wv_q && cur_hit)
		begin
			mark_q[wd1_q] <= 1'b1;
			scnt_q <= scnt_q + ADDR_W'(1);
			sfirst_q <= scnt_q == '0 ? wd1_q : sfirst_q;
			slast_q <= wd1_q;
		end
		if (!i_rstn || (restart && st_d == ST_CMP))
		begin
			diff_q <= '0;
			dcnt_q <= '0;
		end
		else if (st_q == ST_CMP && wv_q && cur_diff)
		begin
			diff_q[wd1_q] <= 1'b1;
			dcnt_q <= dcnt_q + ADDR_W'(1);
		end
	end

	assign o_level = lvl_q;
	assign o_armed = st_q == ST_CLEAR || st_q == ST_RUN;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_rec_end;
		st_q == ST_XFER && done && !cmd_arm;
	endsequence
	sequence s_stop_smp;
		sample && stop_h && !cmd_arm && !cmd_stop && !cmd_xfer;
	endsequence

	property p_stop_end;
		s_stop_smp |=> st_q == ST_XFER ##1 !m_we;
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("stop did not end recording");
	property p_store_wptr;
		s_stop_smp ##0 store |=> wptr_q == $past(wptr_q) + ADDR_W'(1);
	endproperty
	a_store_wptr: assert property (p_store_wptr) else $error("traced stop sample lost");
	property p_prio;
		sample && stop_h && jmp_h && !fadv && !cmd_arm |=> lvl_q == $past(lvl_q);
	endproperty
	a_prio: assert property (p_prio) else $error("stop lost priority");
	property p_jump;
		sample && !stop_h && jmp_h && !fadv && !cmd_arm |=> lvl_q == $past(jtgt) && cnt_q == 16'h0;
	endproperty
	a_jump: assert property (p_jump) else $error("jump wrong");
	property p_adv;
		sample && !stop_h && !jmp_h && adv_h && up && !fadv && !cmd_arm
			|=> lvl_q == $past(lvl_q) + 4'h1 && cnt_q == 16'h0;
	endproperty
	a_adv: assert property (p_adv) else $error("advance wrong");
	property p_fadv;
		fadv && up && !cmd_arm |=> lvl_q == $past(lvl_q) + 4'h1 && cnt_q == 16'h0;
	endproperty
	a_fadv: assert property (p_fadv) else $error("forced advance wrong");
	property p_arm;
		cmd_arm |=> st_q == ST_CLEAR && lvl_q == 4'h0 && pass_q == '0 && walk_q == '0;
	endproperty
	a_arm: assert property (p_arm) else $error("arm did not reinitialise");
	property p_flush;
		st_q == ST_RUN && $past(st_q) == ST_CLEAR |-> $past(walk_q) == LAST && wptr_q == FIRST;
	endproperty
	a_flush: assert property (p_flush) else $error("flush incomplete");
	property p_manual;
		s_rec_end ##0 mode_q == MODE_MANUAL |=> st_q == ST_IDLE;
	endproperty
	a_manual: assert property (p_manual) else $error("manual mode rearmed");
	property p_auto;
		s_rec_end ##0 mode_q == MODE_AUTO && !halt_q |=> st_q == (lim_c ? ST_IDLE : ST_CLEAR);
	endproperty
	a_auto: assert property (p_auto) else $error("auto rearm wrong");
	property p_halt;
		st_q == ST_RUN && cmd_stop && !cmd_arm |=> st_q == ST_IDLE && !a_we [*2];
	endproperty
	a_halt: assert property (p_halt) else $error("stop touched display memory");
endmodule
`default_nettype wire

// [dv/tsc_probe.sv]
// Sample source model standing for the probed system
`timescale 1ns/1ps
`default_nettype none
module tsc_probe (
	input wire logic i_clk,
	input wire logic i_en,
	input wire logic [47:0] i_pat,
	output logic o_valid,
	output logic [47:0] o_data
);
	// One sample per enabled cycle; idle data flips so stale values never pass
	initial
	begin
		o_valid = 1'b0;
		o_data = 48'h0;
		forever
		begin
			@(posedge i_clk);
			o_valid <= i_en;
			o_data <= i_en ? i_pat : ~o_data;
		end
	end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the trace sequencer capture core
`timescale 1ns/1ps
`default_nettype none
module tb
	import tsc_pkg::*;
;
	logic clk, rstn, rd, wr, en, valid, waitreq, armed;
	logic [7:0] addr;
	logic [31:0] wdat, rdat, q;
	logic [47:0] pat, sdat;
	logic [3:0] level;
	int bad_count, total_checks;
	// Register rows: address, write value, expected readback
	logic [7:0] ra [6] = '{OFS_PASS, OFS_PASS, OFS_CURS, OFS_LSEL, OFS_LCFG, 8'hFC};
	logic [31:0] rw [6] = '{32'h0, 32'h270F, 32'h0202_0005, 32'h5, 32'h0, 32'hFFFF_FFFF};
	logic [31:0] re [6] = '{32'h1, 32'h270F, 32'h0202_0005, 32'h5, 32'h1, 32'h0};
	tsc_core dut (.i_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
		.i_smp_valid(valid), .i_smp_data(sdat), .o_level(level), .o_armed(armed));
	tsc_probe probe (.i_clk(clk), .i_en(en), .i_pat(pat), .o_valid(valid), .o_data(sdat));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task conclude();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Held until waitrequest is seen low; read data taken at that edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (waitreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(64'(q), 64'(e));
	endtask
	task lvl(input logic [3:0] l, input logic [31:0] c, input logic [15:0] k);
		bus(1'b1, OFS_LSEL, {28'h0, l});
		bus(1'b1, OFS_LCFG, c);
		bus(1'b1, OFS_LCOND, {16'h0, k});
	endtask
	// Poll state; bound covers a transfer plus a flush
	task wst(input logic [2:0] s);
		int k;
		k = 0;
		do
		begin
			bus(1'b0, OFS_STAT, 32'h0);
			k++;
		end
		while (q[2:0] !== s && k < 600);
		chk(64'(q[2:0]), 64'(s));
	endtask
	task smp(input logic [47:0] p);
		@(posedge clk);
		en <= 1'b1;
		pat <= p;
		@(posedge clk);
		en <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Display memory word read back through the debug window
	task mem(input logic [9:0] a, input logic [47:0] d, input logic [3:0] l);
		bus(1'b1, OFS_MADDR, {14'h0, 2'h1, 6'h0, a});
		repeat (2) @(posedge clk);
		rdchk(OFS_MDAT_LO, d[31:0]);
		bus(1'b0, OFS_MDAT_HI, 32'h0);
		chk(64'(q[19:0]), 64'({l, d[47:32]}));
	endtask
	initial
	begin
		#250000;
		bad_count++;
		conclude();
	end
	initial
	begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h0;
		wdat = 32'h0;
		en = 1'b0;
		pat = 48'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(64'(level), 64'h0);
		chk(64'(armed), 64'h0);
		rdchk(OFS_LCOND, 32'h2222);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b1, ra[i], rw[i]);
			rdchk(ra[i], re[i]);
		end
		// Advance, then stop; both samples traced
		lvl(4'h0, 32'h1, 16'h1122);
		lvl(4'h1, 32'h1, 16'h1211);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_CMD, 32'h1);
		wst(3'h2);
		chk(64'(armed), 64'h1);
		smp(48'h1234_5678_9ABC);
		chk(64'(level), 64'h1);
		smp(48'hFEDC_BA98_7654);
		wst(3'h0);
		chk(64'(level), 64'h1);
		mem(10'h3, 48'h1234_5678_9ABC, 4'h0);
		mem(10'h4, 48'hFEDC_BA98_7654, 4'h1);
		// Jump wins over advance, forced advance, re-arm, stop command
		lvl(4'h0, 32'h0005_0001, 16'h2112);
		lvl(4'h5, 32'h1, 16'h2222);
		bus(1'b1, OFS_CMD, 32'h1);
		wst(3'h2);
		smp(48'h0);
		chk(64'(level), 64'h5);
		bus(1'b1, OFS_CMD, 32'h2);
		repeat (3) @(posedge clk);
		chk(64'(level), 64'h6);
		bus(1'b1, OFS_CMD, 32'h1);
		wst(3'h2);
		chk(64'(level), 64'h0);
		bus(1'b1, OFS_CMD, 32'h8);
		wst(3'h0);
		mem(10'h3, 48'h1234_5678_9ABC, 4'h0);
		// Repeating mode halts at a pass limit of two
		lvl(4'h0, 32'h1, 16'h1221);
		bus(1'b1, OFS_PASS, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_CMD, 32'h1);
		wst(3'h2);
		smp(48'h1);
		wst(3'h2);
		smp(48'h2);
		wst(3'h0);
		chk(64'(q[29:16]), 64'h2);
		mem(10'h3, 48'h2, 4'h0);
		// Search A for all-zero words, then windowed compares against B
		bus(1'b1, OFS_CTRL, 32'h3);
		bus(1'b1, OFS_SMSK_LO, 32'hFFFF_FFFF);
		bus(1'b1, OFS_SMSK_HI, 32'hFFFF);
		bus(1'b1, OFS_CMD, 32'h10);
		wst(3'h0);
		rdchk(OFS_SRES, 32'h0202_0000);
		rdchk(OFS_SCNT, 32'h0000_0202);
		mem(10'h3, 48'h2, 4'h0);
		chk(64'(q[20]), 64'h0);
		mem(10'h4, 48'h0, 4'h0);
		chk(64'(q[20]), 64'h1);
		bus(1'b1, OFS_MADDR, 32'h0002_0003);
		bus(1'b1, OFS_MDAT_LO, 32'h2);
		bus(1'b1, OFS_MDAT_HI, 32'h0);
		bus(1'b1, OFS_MADDR, 32'h0002_0004);
		bus(1'b1, OFS_MDAT_LO, 32'h1);
		bus(1'b1, OFS_MDAT_HI, 32'h0);
		bus(1'b1, OFS_CURS, 32'h0004_0003);
		bus(1'b1, OFS_CMD, 32'h20);
		wst(3'h0);
		rdchk(OFS_SCNT, 32'h0001_0202);
		mem(10'h4, 48'h0, 4'h0);
		chk(64'(q[21]), 64'h1);
		// Masking channel 0 hides the only difference in the window
		bus(1'b1, OFS_CHN_LO, 32'hFFFF_FFFE);
		bus(1'b1, OFS_CMD, 32'h20);
		wst(3'h0);
		rdchk(OFS_SCNT, 32'h0000_0202);
		// Windowed auto stop; count only on advance matches, trace and stop at delay
		lvl(4'h0, 32'h0010_0001, 16'h5225);
		bus(1'b1, OFS_LSEL, 32'h20);
		bus(1'b1, OFS_MSK_LO, 32'h1);
		bus(1'b1, OFS_CMD, 32'h1);
		wst(3'h2);
		smp(48'h1);
		smp(48'h2);
		wst(3'h0);
		chk(64'(q[29:16]), 64'h1);
		mem(10'h3, 48'h2, 4'h0);
		conclude();
	end
endmodule
`default_nettype wire
